// ### inc/lddrs_pkg.sv
// Shared constants, field layout and types of the loss detector block
package lddrs_pkg;
  // Clock rates; the oscillator step is derived from them
  localparam longint CLK_HZ = 200_000_000;
  localparam longint LINE_HZ = 2_048_000;
  localparam logic [31:0] DCO_NOMINAL = 32'(((64'h1 << 32) * LINE_HZ) / CLK_HZ);

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DETECT = 8'h04;
  localparam logic [7:0] OFF_RECOVER = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;

  // Control register bit positions
  localparam int C_DIG = 0;
  localparam int C_OPT = 1;
  localparam int C_RIL = 2;
  localparam int C_CLOS = 5;
  localparam int C_SCI = 6;
  localparam int C_SCF = 7;
  localparam int C_DCF = 8;
  localparam int C_DCS = 9;
  localparam int C_MAS = 10;
  localparam int C_SSYF = 11;
  localparam int C_EQ = 12;
  localparam int C_MASK = 13;
  localparam int CTRL_W = 14;
  localparam int LEVEL_W = 3;

  // Status register: los, event, source(2), blank, pin active
  localparam int ST_EVENT = 1;
  localparam int STATUS_W = 6;

  // Synchronised pin vector layout
  localparam int PIN_LINE = 0;
  localparam int PIN_REF = 1;
  localparam int PIN_POS = 2;
  localparam int PIN_NEG = 3;
  localparam int PIN_OPT = 4;
  localparam int PIN_LVL = 5;
  localparam int PIN_W = 8;

  // Counting constants
  localparam int BYTE_W = 8;
  localparam int DIV8_W = 8;
  localparam int TICKS_PER_8K = 1 << DIV8_W;
  localparam int DETECT_SHIFT = 4;
  localparam logic [12:0] DETECT_MAX = 13'h1000;
  localparam logic [12:0] BLANK_PERIODS = 13'h0008;
  localparam logic [7:0] RECOVER_MIN = 8'h01;

  // Oscillator trim loop
  localparam int TRIM_W = 24;
  localparam logic [23:0] TRIM_STEP_FAST = 24'h00_03E8;
  localparam logic [23:0] TRIM_STEP_SLOW = TRIM_STEP_FAST / 24'h00_000A;
  localparam logic signed [23:0] TRIM_LIMIT = 24'sh04_0000;

  typedef enum logic [1:0] {SRC_LINE, SRC_PIN, SRC_CENTRE, SRC_FREE} lddrs_src_e;

  // Number of no-pulse periods that raise the alarm; zero means the top value
  function automatic logic [12:0] detect_limit(input logic [7:0] count);
    detect_limit = (count == 8'h00) ? DETECT_MAX : (13'(count) << DETECT_SHIFT);
  endfunction

  // Oscillator ticks without a reference edge that mean the reference is gone
  function automatic logic [15:0] gap_limit(input logic is8k, input int periods);
    gap_limit = is8k ? 16'(periods * TICKS_PER_8K) : 16'(periods);
  endfunction
endpackage

// ### design/lddrs_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
module lddrs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] din_in,
  output logic [WIDTH-1:0] dout_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } lddrs_sync_s;

  lddrs_sync_s state;
  lddrs_sync_s next_state;

  // First stage feeds only the second, never any logic
  always_comb begin
    next_state.meta = din_in;
    next_state.stable = state.meta;
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign dout_out = state.stable;
endmodule

// ### design/lddrs_mem.sv
// Elastic buffer storage with registered read data
module lddrs_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0] rdata;
  } lddrs_mem_s;

  lddrs_mem_s state;
  lddrs_mem_s next_state;

  // Write port and registered read port; read sees the old word on a collision
  always_comb begin
    next_state = state;
    if (we_in) begin
      next_state.cells[waddr_in] = wdata_in;
    end
    next_state.rdata = state.cells[raddr_in];
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_out = state.rdata;
endmodule

// ### design/lddrs_top.sv
// Loss-of-signal detector, de-jitter oscillator and reference selection
module lddrs_top #(
  parameter int DEPTH = 64,
  parameter int MISS_PERIODS = 3
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic line_clock_in,
  input wire logic sync_ref_in,
  input wire logic dual_rail_positive_in,
  input wire logic dual_rail_negative_in,
  input wire logic optical_data_in,
  input wire logic [2:0] pulse_level_in,
  output logic los_out,
  output logic irq_out,
  output logic rx_data_out,
  output logic receive_system_clock_out,
  output logic auxiliary_clock_out,
  output logic eight_khz_clock_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] HALF = AW'(DEPTH / 2);

  typedef struct packed {
    logic [lddrs_pkg::CTRL_W-1:0] ctrl;
    logic [7:0] loss_detect_count;
    logic [7:0] loss_recover_count;
    logic ack;
    logic [31:0] dat;
    logic line_prev;
    logic pin_prev;
    logic [1:0] settle;
    logic pulse_per;
    logic pulse_bit;
    logic [12:0] no_pulse;
    logic [7:0] recover_cnt;
    logic los;
    logic loss_event;
    logic irq;
    logic blank;
    logic [31:0] acc;
    logic signed [lddrs_pkg::TRIM_W-1:0] trim;
    logic [lddrs_pkg::DIV8_W-1:0] tick8;
    logic [15:0] ref_gap;
    logic [15:0] pin_gap;
    lddrs_pkg::lddrs_src_e src;
    logic [lddrs_pkg::BYTE_W-1:0] shift_in;
    logic [2:0] bit_in;
    logic [AW-1:0] wptr;
    logic mem_we;
    logic [AW-1:0] mem_waddr;
    logic [lddrs_pkg::BYTE_W-1:0] mem_wdata;
    logic [lddrs_pkg::BYTE_W-1:0] shift_out;
    logic [2:0] bit_out;
    logic [AW-1:0] rptr;
    logic rx_data;
    logic dco_clk;
  } lddrs_state_s;

  lddrs_state_s state;
  lddrs_state_s next_state;

  logic [lddrs_pkg::PIN_W-1:0] pins;
  logic [lddrs_pkg::BYTE_W-1:0] mem_rdata;
  logic [AW-1:0] rd_addr;
  logic [lddrs_pkg::STATUS_W-1:0] status;
  logic [31:0] wr;
  logic bus_req;
  logic line_edge;
  logic pin_edge;
  logic ref_edge;
  logic tick;
  logic is8k;
  logic pulse;
  logic late;
  logic pin_active;
  logic missing;
  logic [32:0] sum;
  logic [12:0] det_lim;
  logic [7:0] rcv_lim;
  logic [23:0] step;
  logic signed [lddrs_pkg::TRIM_W-1:0] trim_adj;
  lddrs_pkg::lddrs_src_e src;

  // Named views of the control word
  logic digital_interface_select;
  logic optical_select;
  logic [lddrs_pkg::LEVEL_W-1:0] receive_level_threshold;
  logic clear_data_on_loss;
  logic state_change_irq_enable;
  logic corner_frequency_select;
  logic centring_disable;
  logic reference_switch_disable;
  logic master_mode_bit;
  logic reference_frequency_select;
  logic equaliser_enable;
  logic loss_irq_mask;

  assign digital_interface_select = state.ctrl[lddrs_pkg::C_DIG];
  assign optical_select = state.ctrl[lddrs_pkg::C_OPT];
  assign receive_level_threshold = state.ctrl[lddrs_pkg::C_RIL +: lddrs_pkg::LEVEL_W];
  assign clear_data_on_loss = state.ctrl[lddrs_pkg::C_CLOS];
  assign state_change_irq_enable = state.ctrl[lddrs_pkg::C_SCI];
  assign corner_frequency_select = state.ctrl[lddrs_pkg::C_SCF];
  assign centring_disable = state.ctrl[lddrs_pkg::C_DCF];
  assign reference_switch_disable = state.ctrl[lddrs_pkg::C_DCS];
  assign master_mode_bit = state.ctrl[lddrs_pkg::C_MAS];
  assign reference_frequency_select = state.ctrl[lddrs_pkg::C_SSYF];
  assign equaliser_enable = state.ctrl[lddrs_pkg::C_EQ];
  assign loss_irq_mask = state.ctrl[lddrs_pkg::C_MASK];

  // Register read mux; unmapped offsets read as zero
  function automatic logic [31:0] read_reg(input logic [7:0] adr, input lddrs_state_s s,
                                           input logic [lddrs_pkg::STATUS_W-1:0] st);
    case (adr)
      lddrs_pkg::OFF_CTRL: read_reg = 32'(s.ctrl);
      lddrs_pkg::OFF_DETECT: read_reg = 32'(s.loss_detect_count);
      lddrs_pkg::OFF_RECOVER: read_reg = 32'(s.loss_recover_count);
      lddrs_pkg::OFF_STATUS: read_reg = 32'(st);
      default: read_reg = '0;
    endcase
  endfunction

  // Byte-lane merge so that sel picks which lanes a write touches
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
  endfunction

  // Every pin crosses two flops before any logic looks at it
  lddrs_sync #(
    .WIDTH(lddrs_pkg::PIN_W)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .din_in({pulse_level_in, optical_data_in, dual_rail_negative_in,
             dual_rail_positive_in, sync_ref_in, line_clock_in}),
    .dout_out(pins)
  );

  // Read pointer trails the write pointer by half the buffer
  assign rd_addr = state.rptr + HALF;

  lddrs_mem #(
    .WIDTH(lddrs_pkg::BYTE_W),
    .DEPTH(DEPTH)
  ) u_mem (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .we_in(state.mem_we),
    .waddr_in(state.mem_waddr),
    .wdata_in(state.mem_wdata),
    .raddr_in(rd_addr),
    .rdata_out(mem_rdata)
  );

  assign status = {pin_active, state.blank, state.src, state.loss_event, state.los};

  // All next-state logic of the block
  always_comb begin
    next_state = state;
    next_state.mem_we = 1'b0;
    bus_req = wb_cyc_in & wb_stb_in;
    wr = merge(read_reg(wb_adr_in, state, status), wb_dat_in, wb_sel_in);
    // Edges count only once the synchroniser holds real pin levels, so that a
    // pin idling high gives no false edge after reset
    if (state.settle != '1) begin
      next_state.settle = state.settle + 2'h1;
    end
    line_edge = pins[lddrs_pkg::PIN_LINE] & ~state.line_prev & (&state.settle);
    pin_edge = pins[lddrs_pkg::PIN_REF] & ~state.pin_prev & (&state.settle);
    next_state.line_prev = pins[lddrs_pkg::PIN_LINE];
    next_state.pin_prev = pins[lddrs_pkg::PIN_REF];
    det_lim = lddrs_pkg::detect_limit(state.loss_detect_count);
    rcv_lim = (state.loss_recover_count == 8'h00) ? lddrs_pkg::RECOVER_MIN
                                                  : state.loss_recover_count;

    // Bus slave: ack one cycle after the request, write lands on the ack edge
    next_state.ack = bus_req & ~state.ack;
    if (bus_req && !state.ack) begin
      next_state.dat = read_reg(wb_adr_in, state, status);
    end
    if (bus_req && state.ack && wb_we_in) begin
      case (wb_adr_in)
        lddrs_pkg::OFF_CTRL: next_state.ctrl = wr[lddrs_pkg::CTRL_W-1:0];
        lddrs_pkg::OFF_DETECT: next_state.loss_detect_count = wr[7:0];
        lddrs_pkg::OFF_RECOVER: next_state.loss_recover_count = wr[7:0];
        lddrs_pkg::OFF_STATUS: begin
          if (wb_sel_in[0] && wb_dat_in[lddrs_pkg::ST_EVENT]) begin
            next_state.loss_event = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Pulse decision per interface type
    if (digital_interface_select) begin
      pulse = optical_select ? pins[lddrs_pkg::PIN_OPT]
                             : (pins[lddrs_pkg::PIN_POS] | pins[lddrs_pkg::PIN_NEG]);
    end else begin
      pulse = pins[lddrs_pkg::PIN_LVL +: lddrs_pkg::LEVEL_W] >= receive_level_threshold;
    end

    // Numerically controlled oscillator; carry out is one bit period
    sum = {1'b0, state.acc} + {1'b0, lddrs_pkg::DCO_NOMINAL} + 33'(state.trim);
    tick = sum[32];
    next_state.acc = sum[31:0];
    next_state.dco_clk = sum[31];
    if (tick) begin
      next_state.tick8 = state.tick8 + 1'b1;
    end

    // Pin counts as applied while its edges keep coming; the reset value means absent
    pin_active = state.pin_gap != '0;
    if (pin_edge) begin
      next_state.pin_gap = lddrs_pkg::gap_limit(reference_frequency_select,
                                                MISS_PERIODS);
    end else if (tick && pin_active) begin
      next_state.pin_gap = state.pin_gap - 16'h0001;
    end

    // Reference selection from mode, alarm and pin activity
    if (master_mode_bit) begin
      if (pin_active) begin
        src = lddrs_pkg::SRC_PIN;
      end else if (centring_disable) begin
        src = lddrs_pkg::SRC_FREE;
      end else begin
        src = lddrs_pkg::SRC_CENTRE;
      end
    end else if (!state.los || reference_switch_disable) begin
      src = lddrs_pkg::SRC_LINE;
    end else if (pin_active && !reference_frequency_select) begin
      src = lddrs_pkg::SRC_PIN;
    end else if (centring_disable) begin
      src = lddrs_pkg::SRC_FREE;
    end else begin
      src = lddrs_pkg::SRC_CENTRE;
    end
    next_state.src = src;

    // Phase comparison against the chosen reference
    is8k = (src == lddrs_pkg::SRC_PIN) && reference_frequency_select;
    ref_edge = (src == lddrs_pkg::SRC_PIN) ? pin_edge : line_edge;
    missing = state.ref_gap >= lddrs_pkg::gap_limit(is8k, MISS_PERIODS);
    late = is8k ? state.tick8[lddrs_pkg::DIV8_W-1] : state.acc[31];
    if (ref_edge) begin
      next_state.ref_gap = '0;
    end else if (tick && !missing) begin
      next_state.ref_gap = state.ref_gap + 1'b1;
    end

    // Slow corner uses a tenth of the step, trading lock speed for filtering
    step = corner_frequency_select ? lddrs_pkg::TRIM_STEP_SLOW
                                   : lddrs_pkg::TRIM_STEP_FAST;
    trim_adj = late ? state.trim + signed'(step) : state.trim - signed'(step);
    if (trim_adj > lddrs_pkg::TRIM_LIMIT) begin
      trim_adj = lddrs_pkg::TRIM_LIMIT;
    end else if (trim_adj < -lddrs_pkg::TRIM_LIMIT) begin
      trim_adj = -lddrs_pkg::TRIM_LIMIT;
    end
    case (src)
      lddrs_pkg::SRC_CENTRE: next_state.trim = '0;
      lddrs_pkg::SRC_FREE: next_state.trim = state.trim;
      lddrs_pkg::SRC_LINE,
      lddrs_pkg::SRC_PIN: begin
        if (missing && !centring_disable) begin
          next_state.trim = '0;
        end else if (ref_edge) begin
          next_state.trim = trim_adj;
        end
      end
      default: next_state.trim = '0;
    endcase

    // Pulse flags, one per bit period of each clock
    if (pulse) begin
      next_state.pulse_per = 1'b1;
      next_state.pulse_bit = 1'b1;
    end

    // Loss detection and recovery, stepped once per oscillator period
    if (tick) begin
      next_state.pulse_per = pulse;
      if (state.pulse_per) begin
        next_state.no_pulse = '0;
        if (state.los) begin
          if (state.recover_cnt + 8'h01 >= rcv_lim) begin
            next_state.los = 1'b0;
            next_state.recover_cnt = '0;
          end else begin
            next_state.recover_cnt = state.recover_cnt + 8'h01;
          end
        end
      end else begin
        if (state.no_pulse < det_lim) begin
          next_state.no_pulse = state.no_pulse + 13'h0001;
        end
        if (!state.los && state.no_pulse + 13'h0001 >= det_lim) begin
          next_state.los = 1'b1;
          next_state.recover_cnt = '0;
        end
      end
    end

    // Event flag; a new event wins over a clear in the same cycle
    if ((next_state.los && !state.los) ||
        (!next_state.los && state.los && state_change_irq_enable)) begin
      next_state.loss_event = 1'b1;
    end
    next_state.irq = next_state.loss_event & ~next_state.ctrl[lddrs_pkg::C_MASK];

    // Blanking starts a few periods into a gap, ahead of the alarm
    next_state.blank = clear_data_on_loss & equaliser_enable &
                       (next_state.los | (state.no_pulse >= lddrs_pkg::BLANK_PERIODS));

    // Buffer write side on the recovered line clock
    if (line_edge) begin
      next_state.pulse_bit = pulse;
      next_state.shift_in = {state.shift_in[lddrs_pkg::BYTE_W-2:0],
                             state.pulse_bit & ~state.blank};
      next_state.bit_in = state.bit_in + 3'h1;
      if (state.bit_in == '1) begin
        next_state.mem_we = 1'b1;
        next_state.mem_waddr = state.wptr;
        next_state.mem_wdata = {state.shift_in[lddrs_pkg::BYTE_W-2:0],
                                state.pulse_bit & ~state.blank};
        next_state.wptr = state.wptr + 1'b1;
      end
    end

    // Buffer read side on the de-jittered oscillator clock
    if (tick) begin
      next_state.rx_data = state.shift_out[lddrs_pkg::BYTE_W-1];
      next_state.bit_out = state.bit_out + 3'h1;
      if (state.bit_out == '1) begin
        next_state.shift_out = mem_rdata;
        next_state.rptr = state.rptr + 1'b1;
      end else begin
        next_state.shift_out = state.shift_out << 1;
      end
    end

    // Output clears at once while blanking, not only after old bytes drain
    if (next_state.blank) begin
      next_state.rx_data = 1'b0;
    end
  end

  // Single state register; synchronous reset to all zero
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign wb_dat_out = state.dat;
  assign wb_ack_out = state.ack;
  assign los_out = state.los;
  assign irq_out = state.irq;
  assign rx_data_out = state.rx_data;
  assign receive_system_clock_out = state.dco_clk;
  assign auxiliary_clock_out = state.dco_clk;
  assign eight_khz_clock_out = state.tick8[lddrs_pkg::DIV8_W-1];
endmodule

// ### bench/lddrs_line_model.sv
// Far-end line transmitter and reference clock source
module lddrs_line_model (
  input wire logic sys_clk_in,
  input wire logic pulses_on_in,
  input wire logic ref_on_in,
  input wire logic [2:0] amp_in,
  output logic line_clock_out,
  output logic sync_ref_out,
  output logic pos_out,
  output logic neg_out,
  output logic opt_out,
  output logic [2:0] level_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] div = 7'h00;
  logic rail = 1'b0;
  logic mark;
  // Bit period of 98 clocks, near the nominal rate; marks alternate rails
  always @(posedge sys_clk_in) begin
    div <= (div == 7'h61) ? 7'h00 : div + 7'h01;
    if (div == 7'h61) begin
      rail <= ~rail;
    end
  end
  // A silent line gives zero on every rail and a zero level
  assign mark = pulses_on_in && (div < 7'h31);
  assign line_clock_out = div < 7'h31;
  assign sync_ref_out = ref_on_in ? (div < 7'h31) : 1'b1; // Absent pin is tied high
  assign pos_out = mark && rail;
  assign neg_out = mark && !rail;
  assign opt_out = mark;
  assign level_out = mark ? amp_in : 3'h0;
endmodule

// ### bench/lddrs_top_assertions.sv
// Checker of bus answers, alarm timing and interrupts at the top ports
module lddrs_top_assertions (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic wb_ack_out,
  input wire logic dual_rail_positive_in,
  input wire logic dual_rail_negative_in,
  input wire logic optical_data_in,
  input wire logic los_out,
  input wire logic irq_out,
  input wire logic rx_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  logic [13:0] ctl;
  logic [7:0] det;
  logic [19:0] quiet;
  logic [19:0] lim;
  // Shadow of control and detect count; the bench writes all lanes
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ctl <= 14'h0000;
      det <= 8'h00;
    end else if (wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out) begin
      if (wb_adr_in == lddrs_pkg::OFF_CTRL) begin
        ctl <= wb_dat_in[13:0];
      end
      if (wb_adr_in == lddrs_pkg::OFF_DETECT) begin
        det <= wb_dat_in[7:0];
      end
    end
  end
  // Clocks since the last mark on any rail, saturating
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || dual_rail_positive_in || dual_rail_negative_in || optical_data_in) begin
      quiet <= 20'h0_0000;
    end else if (quiet != 20'hF_FFFF) begin
      quiet <= quiet + 20'h0_0001;
    end
  end
  // Periods to alarm; zero stands for the top count
  assign lim = (det == 8'h00) ? 20'h0_1000 : {8'h00, det, 4'h0};
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_open_rise;
    $rose(los_out) && !ctl[13];
  endsequence
  a_ack_latency: assert property (s_req |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  a_loss_irq_raise: assert property (s_open_rise |-> ##[0:2] irq_out)
    else $error("loss alarm without interrupt");
  a_mask_holds_irq: assert property (ctl[13] && $past(ctl[13]) |-> !irq_out)
    else $error("masked interrupt seen");
  a_change_irq: assert property (
    $fell(los_out) && ctl[6] && !ctl[13] |-> ##[0:2] irq_out)
    else $error("alarm clear without interrupt");
  a_loss_not_early: assert property (
    $rose(los_out) && ctl[0] |-> quiet >= (lim - 20'h1) * 97)
    else $error("alarm before count of empty periods");
  a_loss_not_late: assert property (
    ctl[0] && quiet > (lim + 20'h2) * 99 |-> los_out)
    else $error("alarm missing after empty periods");
  a_data_blanked: assert property (
    ctl[12] && ctl[5] && los_out && $past(los_out) |-> !rx_data_out)
    else $error("data not blanked during loss");
endmodule
bind lddrs_top lddrs_top_assertions i_lddrs_top_assertions (.sys_clk_in, .reset_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_in, .wb_ack_out, .dual_rail_positive_in,
  .dual_rail_negative_in, .optical_data_in, .los_out, .irq_out, .rx_data_out);

// ### bench/lddrs_top_test.sv
// Self-checking bench: registers, alarm timing, interrupts and reference choice
module lddrs_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic pulses_on = 1'b1;
  logic ref_on = 1'b0;
  logic [2:0] amp = 3'h7;
  logic [31:0] rdat, got;
  logic ack, los, irq, rxd, lclk, sref, pos, neg, opt;
  logic [2:0] lvl;
  logic [31:0] ctl_tab [5] = '{32'h0000_2001, 32'h0000_2201, 32'h0000_2401, 32'h0000_2401,
    32'h0000_2501};
  logic ref_tab [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [31:0] src_tab [5] = '{32'h1, 32'h0, 32'h1, 32'h2, 32'h3};
  int err_count = 0;
  int checked = 0;
  int n;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Small buffer so that marks reach the data output well within the run
  lddrs_top #(.DEPTH(8)) i_lddrs_top (.sys_clk_in(clk), .reset_in(rst), .wb_cyc_in(cyc),
    .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .line_clock_in(lclk), .sync_ref_in(sref), .dual_rail_positive_in(pos),
    .dual_rail_negative_in(neg), .optical_data_in(opt), .pulse_level_in(lvl), .los_out(los),
    .irq_out(irq), .rx_data_out(rxd), .receive_system_clock_out(), .auxiliary_clock_out(),
    .eight_khz_clock_out());
  lddrs_line_model i_lddrs_line_model (.sys_clk_in(clk), .pulses_on_in(pulses_on),
    .ref_on_in(ref_on), .amp_in(amp), .line_clock_out(lclk), .sync_ref_out(sref),
    .pos_out(pos), .neg_out(neg), .opt_out(opt), .level_out(lvl));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle, held until ack is sampled high; read data taken there
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k == 20) begin
      err_count++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 32'h0000_0000);
    check(what, got, exp);
  endtask
  // Bounded wait for the alarm level; n holds the cycles taken
  task automatic wait_los(input logic v, input int lim);
    n = 0;
    while (los !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n == lim) begin
      err_count++;
      print_verdict();
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0000_0000, "ctrl");
    rd(8'h04, 32'h0000_0000, "detect");
    rd(8'h08, 32'h0000_0000, "recover");
    rd(8'h0C, 32'h0000_0000, "status");
    bus(8'h10, 1'b1, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_0000, "unmapped");
    bus(8'h00, 1'b1, 32'hFFFF_0000);
    rd(8'h00, 32'h0000_0000, "ctrl upper");
    $display("test registers done");
    // Digital dual rail, long haul with blanking, N of 16, two to recover
    bus(8'h04, 1'b1, 32'h0000_0001);
    bus(8'h08, 1'b1, 32'h0000_0002);
    bus(8'h00, 1'b1, 32'h0000_1021);
    pulses_on <= 1'b0;
    wait_los(1'b1, 3000);
    check("detect time", n >= 1455 && n <= 1900, 1);
    repeat (3) @(posedge clk);
    check("irq on loss", irq, 1);
    check("blanked data", rxd, 0);
    rd(8'h0C, 32'h0000_001B, "status in loss");
    pulses_on <= 1'b1;
    wait_los(1'b0, 600);
    check("recover time", n >= 90 && n <= 500, 1);
    check("irq sticky", irq, 1);
    bus(8'h0C, 1'b1, 32'h0000_0002);
    repeat (3) @(posedge clk);
    check("irq cleared", irq, 0);
    rd(8'h0C, 32'h0000_0000, "status clear");
    $display("test detect and recover done");
    // Clear of the alarm interrupts only with state change enabled
    bus(8'h00, 1'b1, 32'h0000_0043);
    pulses_on <= 1'b0;
    wait_los(1'b1, 3000);
    bus(8'h0C, 1'b1, 32'h0000_0002);
    pulses_on <= 1'b1;
    wait_los(1'b0, 600);
    repeat (3) @(posedge clk);
    check("irq on clear", irq, 1);
    bus(8'h0C, 1'b1, 32'h0000_0002);
    bus(8'h00, 1'b1, 32'h0000_2001);
    pulses_on <= 1'b0;
    wait_los(1'b1, 3000);
    repeat (3) @(posedge clk);
    check("masked irq", irq, 0);
    rd(8'h0C, 32'h0000_000B, "masked status");
    $display("test interrupts done");
    // Reference choice while the alarm stands
    for (int i = 0; i < 5; i++) begin
      bus(8'h00, 1'b1, ctl_tab[i]);
      ref_on <= ref_tab[i];
      repeat (1200) @(posedge clk);
      bus(8'h0C, 1'b0, 32'h0000_0000);
      check("source", (got >> 2) & 32'h3, src_tab[i]);
    end
    $display("test reference choice done");
    // Analogue threshold 4: equal level is a pulse, lower is none, rails ignored
    bus(8'h00, 1'b1, 32'h0000_0010);
    amp <= 3'h4;
    pulses_on <= 1'b1;
    wait_los(1'b0, 600);
    amp <= 3'h3;
    wait_los(1'b1, 3000);
    check("weak level loss", n >= 1455 && n <= 1900, 1);
    $display("test analogue done");
    // Steady marks reach the data output once the half-buffer delay has passed
    bus(8'h00, 1'b1, 32'h0000_0000);
    n = 0;
    while (rxd !== 1'b1 && n < 8000) begin
      @(posedge clk);
      n++;
    end
    check("data through buffer", n < 8000, 1);
    $display("test data path done");
    print_verdict();
  end
endmodule
